// ===== core/psf_params.svh
`ifndef PSF_PARAMS_SVH
`define PSF_PARAMS_SVH
// ********************
// Register offsets
// ********************
`define PSF_A_OUT_XL   8'h28
`define PSF_A_OUT_L    8'h29
`define PSF_A_OUT_H    8'h2A
`define PSF_A_CTRL     8'h2E
`define PSF_A_STAT     8'h2F
`define PSF_A_THS_L    8'h30
`define PSF_A_THS_H    8'h31
`define PSF_A_OFS_L    8'h39
`define PSF_A_OFS_H    8'h3A
// ********************
// Reset values
// ********************
`define PSF_RST_CTRL   8'h00
`define PSF_RST_THS    8'h00
`define PSF_RST_OFS_L  8'h38
`define PSF_RST_OFS_H  8'h00
`define PSF_RST_LIVE   24'h02_F800
// ********************
// Fields and codes
// ********************
`define PSF_MODE_MSB   7
`define PSF_MODE_LSB   5
`define PSF_LVL_MSB    4
`define PSF_M_BYPASS   3'h0
`define PSF_M_FILL     3'h1
`define PSF_M_STREAM   3'h2
`define PSF_M_S2F      3'h3
`define PSF_M_B2S      3'h4
`define PSF_M_MEAN     3'h6
`define PSF_M_B2F      3'h7
`define PSF_AVG2       5'h01
`define PSF_AVG4       5'h03
`define PSF_AVG8       5'h07
`define PSF_AVG16      5'h0F
`define PSF_AVG32      5'h1F
`define PSF_DEPTH      6'h20
`define PSF_ONE_CNT    6'h01
`define PSF_ONE_PTR    5'h01
`endif

// ===== core/psf_pkg.sv
package psf_pkg;
   typedef enum logic [1:0] {PSF_BYP, PSF_FILL, PSF_STRM, PSF_MEAN} psf_mode_t;
   typedef logic [23:0] psf_sample_t;
endpackage

// ===== core/psf_core.sv
// Behaviour
// - Buffer holds 32 entries of 24 bits, loaded from pressure samples.
// - Three-bit mode field in buffer control register at 0x2E selects operation.
// - Mode 000: buffer disabled and empty; output shows latest conversion.
// - Mode 001: samples fill buffer; samples arriving when full are dropped.
// - With watermark enable set, interrupt when fill level reaches watermark.
// - Mode 100: bypass until trigger, then stream keeping newest samples.
// - Mode 110, no decimation: stream with running average on output registers.
// - In averaging, watermark codes 1,3,7,15,31 select depth 2..32.
// - Mode 111: bypass until trigger, then fill-until-full.
// - In buffered modes output byte reads return buffered data.
// - Each buffer read moves oldest entry to outputs; single or burst.
// - Burst read address wraps from 0x2A to 0x28 while buffer active.
// - Threshold high byte at 0x31, read-write, resets to zero.
// - Signed 16-bit solder offset, low byte 0x39, high byte 0x3A.
// - Control register: mode in bits 7..5, level in 4..0, reset zero.
// - Status: watermark bit 7, full bit 6, empty bit 5, count 4..0.
// - In averaging mode entries are hidden; reads give only the average.
`timescale 1ns/1ps
`include "psf_params.svh"
module psf_core (
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   input  wire logic               smp_valid,
   output      logic               smp_ready,
   input  wire psf_pkg::psf_sample_t smp_data,
   input  wire logic               trigger_event,
   input  wire logic               watermark_irq_enable,
   input  wire logic               mean_decimate,
   input  wire logic [7:0]         reg_addr,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire logic [7:0]         reg_wdata,
   output      logic [7:0]         reg_rdata,
   output      logic [7:0]         reg_next_addr,
   output      logic               watermark_irq,
   output      logic [15:0]        threshold,
   output      logic [15:0]        solder_offset
);
   import psf_pkg::*;

   // ********************
   // Registers
   // ********************
   logic [7:0]  ctrl_reg;
   logic [7:0]  ths_l_reg;
   logic [7:0]  ths_h_reg;
   logic [7:0]  ofs_l_reg;
   logic [7:0]  ofs_h_reg;
   logic [7:0]  rdata_reg;
   logic [7:0]  next_addr_reg;
   logic        trig_reg;
   logic        irq_reg;
   psf_mode_t   mode_next;
   logic [2:0]  mode_code;
   logic [4:0]  level;
   logic        active;
   logic        ctrl_wr;

   assign mode_code = ctrl_reg[`PSF_MODE_MSB:`PSF_MODE_LSB];
   assign level     = ctrl_reg[`PSF_LVL_MSB:0];
   assign ctrl_wr   = reg_wr && reg_addr == `PSF_A_CTRL;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= `PSF_RST_CTRL;
      end else if (ctrl_wr) begin
         ctrl_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ths_l_reg <= `PSF_RST_THS;
         ths_h_reg <= `PSF_RST_THS;
         ofs_l_reg <= `PSF_RST_OFS_L;
         ofs_h_reg <= `PSF_RST_OFS_H;
      end else if (reg_wr) begin
         if (reg_addr == `PSF_A_THS_L) ths_l_reg <= reg_wdata;
         if (reg_addr == `PSF_A_THS_H) ths_h_reg <= reg_wdata;
         if (reg_addr == `PSF_A_OFS_L) ofs_l_reg <= reg_wdata;
         if (reg_addr == `PSF_A_OFS_H) ofs_h_reg <= reg_wdata;
      end
   end
   assign threshold     = {ths_h_reg, ths_l_reg};
   assign solder_offset = {ofs_h_reg, ofs_l_reg};

   // trigger latch, rearmed by any control write
   // Set wins over rearm so a trigger in the write cycle is not lost
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trig_reg <= 1'b0;
      end else if (trigger_event) begin
         trig_reg <= 1'b1;
      end else if (ctrl_wr) begin
         trig_reg <= 1'b0;
      end
   end

   always_comb begin
      case (mode_code)
         `PSF_M_FILL:   mode_next = PSF_FILL;
         `PSF_M_STREAM: mode_next = PSF_STRM;
         `PSF_M_S2F:    mode_next = trig_reg ? PSF_FILL : PSF_STRM;
         `PSF_M_B2S:    mode_next = trig_reg ? PSF_STRM : PSF_BYP;
         `PSF_M_MEAN:   mode_next = mean_decimate ? PSF_STRM : PSF_MEAN;
         `PSF_M_B2F:    mode_next = trig_reg ? PSF_FILL : PSF_BYP;
         default:       mode_next = PSF_BYP;
      endcase
   end
   assign active = mode_next != PSF_BYP;

   // ********************
   // Input skid buffer
   // ********************
   psf_sample_t skid_mem [2];
   logic        skid_wp;
   logic        skid_rp;
   logic [1:0]  skid_cnt;
   logic        in_valid;
   logic        in_ready;
   logic        pop;
   psf_sample_t in_data;

   // Two slots so a stall during a pop loses no sample
   assign smp_ready = skid_cnt != 2'd2;
   assign in_valid  = skid_cnt != 2'd0;
   assign in_data   = skid_mem[skid_rp];
   assign in_ready  = !pop;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         skid_wp  <= 1'b0;
         skid_rp  <= 1'b0;
         skid_cnt <= 2'd0;
      end else begin
         if (smp_valid && smp_ready) skid_wp <= !skid_wp;
         if (in_valid && in_ready) skid_rp <= !skid_rp;
         skid_cnt <= skid_cnt + 2'(smp_valid && smp_ready)
                              - 2'(in_valid && in_ready);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (smp_valid && smp_ready) skid_mem[skid_wp] <= smp_data;
   end

   // ********************
   // Sample buffer
   // ********************
   psf_sample_t mem [32];
   logic [4:0]  wp_reg;
   logic [4:0]  rp_reg;
   logic [5:0]  cnt_reg;
   psf_sample_t live_reg;
   psf_sample_t last_reg;
   logic        push;
   logic        full;
   logic        empty;
   logic        out_rd;

   assign full   = cnt_reg == `PSF_DEPTH;
   assign empty  = cnt_reg == 6'h00;
   assign push   = in_valid && in_ready;
   assign out_rd = reg_rd && reg_addr == `PSF_A_OUT_H;
   // pop only on high byte, never in averaging or when empty
   assign pop    = out_rd && active && mode_next != PSF_MEAN && !empty;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         live_reg <= `PSF_RST_LIVE;
      end else if (push) begin
         live_reg <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wp_reg  <= 5'h00;
         rp_reg  <= 5'h00;
         cnt_reg <= 6'h00;
      end else if (!active) begin
         wp_reg  <= 5'h00;
         rp_reg  <= 5'h00;
         cnt_reg <= 6'h00;
      end else if (push && !(full && mode_next == PSF_FILL)) begin
         wp_reg <= wp_reg + `PSF_ONE_PTR;
         if (full) rp_reg <= rp_reg + `PSF_ONE_PTR;
         else cnt_reg <= cnt_reg + `PSF_ONE_CNT;
      end else if (pop) begin
         rp_reg  <= rp_reg + `PSF_ONE_PTR;
         cnt_reg <= cnt_reg - `PSF_ONE_CNT;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (active && push && !(full && mode_next == PSF_FILL)) mem[wp_reg] <= in_data;
   end

   // popped entry held for the byte reads while the buffer is empty
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         last_reg <= `PSF_RST_LIVE;
      end else if (pop) begin
         last_reg <= mem[rp_reg];
      end
   end

   // ********************
   // Running average
   // ********************
   logic [29:0] sum;
   logic [2:0]  shift;
   logic [4:0]  idx;
   psf_sample_t avg_reg;

   // depth select; reserved codes fall back to newest sample
   always_comb begin
      case (level)
         `PSF_AVG2:  shift = 3'd1;
         `PSF_AVG4:  shift = 3'd2;
         `PSF_AVG8:  shift = 3'd3;
         `PSF_AVG16: shift = 3'd4;
         `PSF_AVG32: shift = 3'd5;
         default:    shift = 3'd0;
      endcase
   end
   // sum of newest entries; wide adder traded for no accumulator drift
   always_comb begin
      sum = 30'h0000_0000;
      idx = 5'h00;
      for (int i = 0; i < 32; i++) begin
         idx = wp_reg - 5'(i) - `PSF_ONE_PTR;
         if (i < (1 << shift)) sum = sum + {{6{mem[idx][23]}}, mem[idx]};
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         avg_reg <= `PSF_RST_LIVE;
      end else begin
         avg_reg <= 24'($signed(sum) >>> shift);
      end
   end

   // ********************
   // Read port
   // ********************
   psf_sample_t out_val;
   logic [7:0]  rd_val;

   always_comb begin
      case (mode_next)
         PSF_BYP:  out_val = live_reg;
         PSF_MEAN: out_val = avg_reg;
         default:  out_val = empty ? last_reg : mem[rp_reg];
      endcase
   end
   always_comb begin
      case (reg_addr)
         `PSF_A_OUT_XL: rd_val = out_val[7:0];
         `PSF_A_OUT_L:  rd_val = out_val[15:8];
         `PSF_A_OUT_H:  rd_val = out_val[23:16];
         `PSF_A_CTRL:   rd_val = ctrl_reg;
         `PSF_A_STAT:   rd_val = {cnt_reg >= {1'b0, level}, full, empty, cnt_reg[4:0]};
         `PSF_A_THS_L:  rd_val = ths_l_reg;
         `PSF_A_THS_H:  rd_val = ths_h_reg;
         `PSF_A_OFS_L:  rd_val = ofs_l_reg;
         `PSF_A_OFS_H:  rd_val = ofs_h_reg;
         default:       rd_val = 8'h00;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg     <= 8'h00;
         next_addr_reg <= 8'h00;
      end else if (reg_rd) begin
         rdata_reg <= rd_val;
         if (active && reg_addr == `PSF_A_OUT_H) next_addr_reg <= `PSF_A_OUT_XL;
         else next_addr_reg <= reg_addr + 8'h01;
      end
   end
   assign reg_rdata     = rdata_reg;
   assign reg_next_addr = next_addr_reg;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= watermark_irq_enable && active && cnt_reg >= {1'b0, level};
      end
   end
   assign watermark_irq = irq_reg;

   // ********************
   // Assertions
   // ********************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence trig_arm_s;
      mode_code == `PSF_M_B2S && !ctrl_wr && trigger_event;
   endsequence
   sequence fill_full_push_s;
      mode_next == PSF_FILL && full && push;
   endsequence

   bypass_empty_a: assert property (!active |=> cnt_reg == 6'h00)
      else $error("buffer not empty in bypass");
   fill_drop_a: assert property (fill_full_push_s |=> wp_reg == $past(wp_reg))
      else $error("sample stored while full");
   trig_stream_a: assert property (trig_arm_s ##1 !ctrl_wr |=> mode_next == PSF_STRM)
      else $error("trigger did not start stream");
   stream_keep_a: assert property (mode_next == PSF_STRM && full && push
      |=> full && rp_reg == $past(rp_reg) + 5'h01)
      else $error("stream did not drop oldest");
   pop_count_a: assert property (pop && !push |=> cnt_reg == $past(cnt_reg) - 6'h01)
      else $error("pop did not reduce count");
   empty_read_a: assert property (out_rd && empty |=> last_reg == $past(last_reg))
      else $error("empty read changed output");
   addr_wrap_a: assert property (reg_rd && active && reg_addr == `PSF_A_OUT_H
      |=> reg_next_addr == `PSF_A_OUT_XL)
      else $error("burst address did not wrap");
   ctrl_write_a: assert property (ctrl_wr |=> ctrl_reg == $past(reg_wdata))
      else $error("control write lost");
   irq_level_a: assert property (watermark_irq_enable && active && !push && !pop
      && cnt_reg >= {1'b0, level} |=> watermark_irq)
      else $error("watermark interrupt missing");
   mean_hide_a: assert property (mode_next == PSF_MEAN && out_rd && !push
      |=> cnt_reg == $past(cnt_reg))
      else $error("entry popped in averaging");
endmodule

// ===== tb/psf_sample_src.sv
`timescale 1ns/1ps
// ********************
// Sample source model
// ********************
module psf_sample_src (
   input  wire logic                 clk_sys,
   input  wire logic                 smp_ready,
   output      logic                 smp_valid,
   output      psf_pkg::psf_sample_t smp_data
);
   import psf_pkg::*;
   initial begin
      smp_valid = 1'b0;
      smp_data  = 24'h00_0000;
   end
   // Offer one word, hold it until taken at an edge with ready high
   task automatic send(input psf_sample_t v);
      logic ok;
      @(posedge clk_sys);
      smp_valid <= 1'b1;
      smp_data  <= v;
      do begin
         #1 ok = smp_ready;
         @(posedge clk_sys);
      end while (!ok);
      smp_valid <= 1'b0;
      // Released line shows inverse, so a stale word is never mistaken for a new one
      smp_data  <= ~v;
   endtask
endmodule

// ===== tb/pressure_sample_fifo_with_averager_tb.sv
`timescale 1ns/1ps
`include "psf_params.svh"
module pressure_sample_fifo_with_averager_tb;
   import psf_pkg::*;
   logic        clk_sys, rst_b, trigger_event, watermark_irq_enable, mean_decimate;
   logic        reg_wr, reg_rd, smp_valid, smp_ready, watermark_irq;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, reg_next_addr, d, na, a, m;
   logic [15:0] threshold, solder_offset;
   logic [23:0] v;
   psf_sample_t smp_data;
   int          failures = 0;
   int          n_checks = 0;
   int          cycles   = 0;
   int          i, j, n;
   // ********************
   // Instances
   // ********************
   psf_core dut (.clk_sys, .rst_b, .smp_valid, .smp_ready, .smp_data, .trigger_event,
      .watermark_irq_enable, .mean_decimate, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .reg_next_addr, .watermark_irq, .threshold, .solder_offset);
   psf_sample_src src (.clk_sys, .smp_ready, .smp_valid, .smp_data);
   // ********************
   // Clock and tasks
   // ********************
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Run is about 1500 cycles; ceiling leaves wide margin
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= ad;
      reg_wdata <= dt;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= ad;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
      na = reg_next_addr;
   endtask
   task automatic rd3();
      rd(`PSF_A_OUT_XL);
      v[7:0] = d;
      rd(`PSF_A_OUT_L);
      v[15:8] = d;
      rd(`PSF_A_OUT_H);
      v[23:16] = d;
   endtask
   task automatic push(input logic [23:0] x);
      src.send(x);
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   // ********************
   // Main sequence
   // ********************
   initial begin
      rst_b = 1'b0;
      trigger_event = 1'b0;
      watermark_irq_enable = 1'b0;
      mean_decimate = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(`PSF_A_CTRL);  chk("ctrl", d, 8'h00);
      rd(`PSF_A_THS_H); chk("ths_h", d, 8'h00);
      rd(`PSF_A_OFS_L); chk("ofs_l", d, 8'h38);
      rd(`PSF_A_OFS_H); chk("ofs_h", d, 8'h00);
      rd(8'h50);        chk("unmapped", d, 8'h00);
      rd3();            chk("live", v, 24'h02_F800);
      chk("no_wrap", na, 8'h2B);
      wr(`PSF_A_THS_H, 8'hA5);
      wr(`PSF_A_OFS_L, 8'h5A);
      wr(`PSF_A_OFS_H, 8'hC3);
      wr(`PSF_A_STAT, 8'h1F);
      rd(`PSF_A_THS_H); chk("ths_h", d, 8'hA5);
      chk("threshold", threshold, 16'hA500);
      chk("offset", solder_offset, 16'hC35A);
      rd(`PSF_A_STAT);  chk("stat", d, 8'hA0);
      push(24'h12_3456);
      rd3();            chk("bypass", v, 24'h12_3456);
      wr(`PSF_A_CTRL, 8'hA0);
      push(24'h65_4321);
      rd3();            chk("mode101", v, 24'h65_4321);
      rd(`PSF_A_STAT);  chk("stat101", d, 8'hA0);
      // Fill mode, watermark four
      @(posedge clk_sys);
      watermark_irq_enable <= 1'b1;
      wr(`PSF_A_CTRL, 8'h24);
      for (i = 1; i <= 3; i++) push(24'(i));
      chk("irq3", watermark_irq, 1'b0);
      push(24'h00_0004);
      chk("irq4", watermark_irq, 1'b1);
      rd(`PSF_A_STAT);  chk("stat4", d, 8'h84);
      for (i = 5; i <= 33; i++) push(24'(i));
      rd(`PSF_A_STAT);  chk("full", d, 8'hC0);
      a = `PSF_A_OUT_XL;
      for (i = 0; i < 96; i++) begin
         rd(a);
         chk("next_addr", na, (a == 8'h2A) ? 8'h28 : a + 8'h01);
         v[8*(i%3) +: 8] = d;
         if (i % 3 == 2) chk("entry", v, 24'(i/3 + 1));
         a = na;
      end
      rd(`PSF_A_STAT);  chk("drained", d, 8'h20);
      chk("irq0", watermark_irq, 1'b0);
      rd(`PSF_A_OUT_H);
      rd(`PSF_A_STAT);  chk("empty_pop", d, 8'h20);
      rd3();            chk("empty_hold", v, 24'h00_0020);
      // Triggered modes: bypass first, then stream or fill
      for (j = 0; j < 2; j++) begin
         m = (j == 0) ? 8'h80 : 8'hE0;
         wr(`PSF_A_CTRL, m);
         push(24'h0F_0000);
         rd(`PSF_A_STAT);  chk("pre_trig", d, 8'hA0);
         @(posedge clk_sys);
         trigger_event <= 1'b1;
         @(posedge clk_sys);
         trigger_event <= 1'b0;
         for (i = 0; i < 34; i++) push(24'(i + 100));
         rd(`PSF_A_STAT);  chk("post_trig", d, 8'hC0);
         rd3();            chk("oldest", v, (j == 0) ? 24'd102 : 24'd100);
      end
      // Averaging: reserved depth code first, then every depth code
      wr(`PSF_A_CTRL, 8'hC0);
      push(24'h00_0777);
      rd3();            chk("mean_rsv", v, 24'h00_0777);
      for (j = 0; j < 5; j++) begin
         n = 2 << j;
         wr(`PSF_A_CTRL, {3'b110, 5'(n - 1)});
         for (i = 1; i <= n; i++) push(24'(8 * i));
         rd3();            chk("mean", v, 24'(4 * (n + 1)));
         rd(`PSF_A_OUT_H);
         rd3();            chk("mean_hold", v, 24'(4 * (n + 1)));
         rd(`PSF_A_STAT);  chk("mean_cnt", d, 8'hC0);
      end
      // Decimation on: averaging code runs as a plain stream
      @(posedge clk_sys);
      mean_decimate <= 1'b1;
      rd3();            chk("decimate", v, 24'h00_0008);
      rd(`PSF_A_STAT);  chk("dec_stat", d, 8'h9F);
      // Plain stream code, then stream that turns to fill on trigger
      wr(`PSF_A_CTRL, 8'h00);
      wr(`PSF_A_CTRL, 8'h40);
      for (i = 0; i < 34; i++) push(24'(i + 200));
      rd3();            chk("stream010", v, 24'h00_00CA);
      wr(`PSF_A_CTRL, 8'h60);
      @(posedge clk_sys);
      trigger_event <= 1'b1;
      @(posedge clk_sys);
      trigger_event <= 1'b0;
      push(24'h00_012C);
      push(24'h00_012D);
      rd(`PSF_A_STAT);  chk("s2f_full", d, 8'hC0);
      rd3();            chk("s2f_oldest", v, 24'h00_00CB);
      print_verdict();
   end
endmodule
